// [logic/cdrmc_pkg.sv]
// ********************************************************************
// Shared constants and types of the clock recovery mode control.
// ********************************************************************
package cdrmc_pkg;

    // ****************************************************************
    // Frequencies, in kHz.
    // ****************************************************************
    // System clock rate of the control logic.
    localparam int unsigned SYS_CLK_KHZ = 10000;
    // Reference clock rate supplied by the system.
    localparam int unsigned REF_CLK_KHZ = 19440;
    // Output clock rate with the high line rate selected.
    localparam int unsigned OUT_HIGH_KHZ = 622080;
    // Output clock rate with the low line rate selected.
    localparam int unsigned OUT_LOW_KHZ = 155520;
    // Loop divide ratios derived from the rates above.
    localparam logic [5:0] RATIO_HIGH = 6'(OUT_HIGH_KHZ / REF_CLK_KHZ);
    localparam logic [5:0] RATIO_LOW = 6'(OUT_LOW_KHZ / REF_CLK_KHZ);

    // ****************************************************************
    // Frequency monitor.
    // ****************************************************************
    // Largest permitted deviation, in parts per million.
    localparam int unsigned PPM_LIMIT = 500;
    // Scale of a ppm figure.
    localparam int unsigned PPM_SCALE = 1000000;
    // Reference edges per measurement window.
    localparam int unsigned WINDOW_REFS_DEFAULT = 2000;
    // Width of the monitor counters.
    localparam int unsigned CNT_W = 20;

    // ****************************************************************
    // Register map and reset values.
    // ****************************************************************
    localparam int unsigned AXI_ADDR_W = 8;
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h08;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h0c;
    localparam logic [7:0] ADDR_FREQ_COUNT = 8'h10;
    // Decoded register indices.
    localparam logic [2:0] IDX_CTRL = 3'h0;
    localparam logic [2:0] IDX_STATUS = 3'h1;
    localparam logic [2:0] IDX_IRQ_STATUS = 3'h2;
    localparam logic [2:0] IDX_IRQ_MASK = 3'h3;
    localparam logic [2:0] IDX_FREQ_COUNT = 3'h4;
    localparam logic [2:0] IDX_NONE = 3'h7;
    // Control bit that forces the loop onto the reference.
    localparam int unsigned CTRL_FORCE_REF = 0;
    localparam logic CTRL_RST = 1'h0;
    // Interrupt bit positions and reset values.
    localparam int unsigned IRQ_W = 4;
    localparam int unsigned IRQ_LOS = 0;
    localparam int unsigned IRQ_LOCK_LOST = 1;
    localparam int unsigned IRQ_LOCK_GAIN = 2;
    localparam int unsigned IRQ_ILLEGAL = 3;
    localparam logic [3:0] IRQ_STATUS_RST = 4'h0;
    localparam logic [3:0] IRQ_MASK_RST = 4'h0;
    // AXI response codes.
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ****************************************************************
    // Types.
    // ****************************************************************
    // Operating mode of the output path.
    typedef enum logic [1:0] {
        MODE_NORMAL = 2'b00,
        MODE_LOS = 2'b01,
        MODE_BYPASS = 2'b10
    } cdrmc_mode_t;

    // Pin inputs from the receiver, the loop and the control straps.
    typedef struct packed {
        logic bypass;
        logic force_reference_lock_n;
        logic signal_present_in;
        logic rate_select_high;
        logic pll_clock_in;
        logic ref_clock_in;
        logic line_data_in;
    } cdrmc_pins_t;

    // Differential clock and data outputs toward the framer.
    typedef struct packed {
        logic clock_out;
        logic clock_out_complement;
        logic data_out;
        logic data_out_complement;
    } cdrmc_line_out_t;

endpackage

// [logic/cdrmc_freq_monitor.sv]
`timescale 1ns/10ps
// ********************************************************************
// Oscillator versus reference frequency monitor.
// ********************************************************************
module cdrmc_freq_monitor
    import cdrmc_pkg::*;
#(
    parameter int unsigned WINDOW_REFS = WINDOW_REFS_DEFAULT
) (
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // Edge ticks and rate.
    input wire logic ref_tick,
    input wire logic osc_tick,
    input wire logic rate_high,
    // Results.
    output logic freq_ok,
    output logic [CNT_W-1:0] measured
);

    // State of the monitor.
    typedef struct packed {
        logic [CNT_W-1:0] ref_cnt;
        logic [CNT_W-1:0] osc_cnt;
        logic [CNT_W-1:0] measured;
        logic freq_ok;
    } cdrmc_mon_state_t;

    // Reset value: not within tolerance until a window has been measured.
    localparam cdrmc_mon_state_t MON_RST = '{default: '0};

    cdrmc_mon_state_t m_q; // Registered state.
    cdrmc_mon_state_t m_d; // Next state.

    // ****************************************************************
    // Counting and comparison.
    // ****************************************************************
    // Count oscillator edges over a fixed count of reference edges, then
    // compare against the expected count with a 500 ppm tolerance.
    always_comb begin
        logic [CNT_W-1:0] expect_cnt;
        logic [CNT_W-1:0] tol_cnt;
        logic [CNT_W-1:0] osc_now;
        logic [CNT_W-1:0] diff;
        expect_cnt = CNT_W'(WINDOW_REFS * (rate_high ? RATIO_HIGH : RATIO_LOW));
        tol_cnt = CNT_W'((64'(expect_cnt) * PPM_LIMIT) / PPM_SCALE);
        osc_now = m_q.osc_cnt + CNT_W'(osc_tick);
        diff = (osc_now > expect_cnt) ? osc_now - expect_cnt : expect_cnt - osc_now;
        m_d = m_q;
        // Saturate rather than wrap so a runaway oscillator stays out of range.
        if (&m_q.osc_cnt) begin
            osc_now = m_q.osc_cnt;
        end
        m_d.osc_cnt = osc_now;
        if (ref_tick) begin
            if (m_q.ref_cnt == CNT_W'(WINDOW_REFS - 1)) begin
                // Window closes: latch the count and judge it.
                m_d.measured = osc_now;
                m_d.freq_ok = (diff <= tol_cnt); // see [R7]
                m_d.ref_cnt = '0;
                m_d.osc_cnt = '0;
            end else begin
                m_d.ref_cnt = m_q.ref_cnt + CNT_W'(1);
            end
        end
    end

    // State register.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            m_q <= MON_RST;
        end else begin
            m_q <= m_d;
        end
    end

    assign freq_ok = m_q.freq_ok;
    assign measured = m_q.measured;

endmodule

// [logic/cdrmc_top.sv]
`timescale 1ns/10ps
// ********************************************************************
// Mode and status control of the line clock and data recovery unit.
// ********************************************************************

// Behaviour
// [R1] Output clock rate follows rate select input.
// [R2] System supplies the fixed reference clock.
// [R3] Loss of signal when forcing inputs low.
// [R4] Loss of signal mutes data low, complement high.
// [R5] Loss of signal keeps loop clock near reference.
// [R6] Loop tracks reference without data or forced.
// [R7] Lock low when frequency off by 500ppm.
// [R8] Lock low when forced onto the reference.
// [R9] Lock high only when locked to data.
// [R10] Normal mode passes loop clock, retimed data.
// [R11] Bypass presents inverted reference clock output.
// [R12] Bypass never high with rate select low.
// [R13] Bypass stays low outside factory test.
module cdrmc_top
    import cdrmc_pkg::*;
#(
    parameter int unsigned WINDOW_REFS = WINDOW_REFS_DEFAULT
) (
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // Pins from receiver, loop and straps.
    input cdrmc_pins_t pins,
    // Line outputs and loop control.
    output cdrmc_line_out_t line_out,
    output logic lock_indicator_pin,
    output logic loop_track_ref,
    output logic [5:0] loop_divide_ratio,
    // Interrupt.
    output logic irq,
    // AXI4-Lite write address channel.
    input wire logic awvalid,
    output logic awready,
    input wire logic [AXI_ADDR_W-1:0] awaddr,
    // AXI4-Lite write data channel.
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    // AXI4-Lite write response channel.
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // AXI4-Lite read address channel.
    input wire logic arvalid,
    output logic arready,
    input wire logic [AXI_ADDR_W-1:0] araddr,
    // AXI4-Lite read data channel.
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp
);

    // ****************************************************************
    // State of the block.
    // ****************************************************************
    typedef struct packed {
        cdrmc_pins_t sync1;          // First synchroniser stage.
        cdrmc_pins_t sync2;          // Second synchroniser stage.
        cdrmc_pins_t prev;           // Delayed copy for edge detection.
        cdrmc_mode_t mode;           // Current output mode.
        cdrmc_line_out_t line;       // Registered line outputs.
        logic lock;                  // Lock indicator.
        logic track_ref;             // Loop forced onto the reference.
        logic [5:0] ratio;           // Loop divide ratio.
        logic ctrl_force_ref;        // Software forcing control.
        logic [IRQ_W-1:0] irq_status; // Sticky events.
        logic [IRQ_W-1:0] irq_mask;  // Interrupt enables.
        logic aw_have;               // Write address held.
        logic [AXI_ADDR_W-1:0] aw_addr;
        logic w_have;                // Write data held.
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } cdrmc_state_t;

    // Reset value; line outputs start in the muted pattern and the loop on the
    // reference, so the muted mode and its tracking flag agree from the first edge.
    localparam cdrmc_state_t STATE_RST = '{
        mode: MODE_LOS,
        line: '{clock_out: 1'b0, clock_out_complement: 1'b1,
                data_out: 1'b0, data_out_complement: 1'b1},
        ratio: RATIO_LOW,
        track_ref: 1'b1,
        ctrl_force_ref: CTRL_RST,
        irq_status: IRQ_STATUS_RST,
        irq_mask: IRQ_MASK_RST,
        bresp: RESP_OKAY,
        rresp: RESP_OKAY,
        default: '0
    };

    cdrmc_state_t s_q; // Registered state.
    cdrmc_state_t s_d; // Next state.
    logic freq_ok;     // Oscillator within tolerance of the reference.
    logic [CNT_W-1:0] freq_count; // Last measured oscillator count.
    logic ref_tick;    // Rising edge of the reference clock.
    logic osc_tick;    // Rising edge of the loop clock.

    // ****************************************************************
    // Address decoding, shared by reads and writes.
    // ****************************************************************
    function automatic logic [2:0] cdrmc_decode(input logic [AXI_ADDR_W-1:0] addr);
        if (addr == ADDR_CTRL) begin
            return IDX_CTRL;
        end else if (addr == ADDR_STATUS) begin
            return IDX_STATUS;
        end else if (addr == ADDR_IRQ_STATUS) begin
            return IDX_IRQ_STATUS;
        end else if (addr == ADDR_IRQ_MASK) begin
            return IDX_IRQ_MASK;
        end else if (addr == ADDR_FREQ_COUNT) begin
            return IDX_FREQ_COUNT;
        end else begin
            return IDX_NONE;
        end
    endfunction

    // Edges are taken from the second stage and its delayed copy only.
    assign ref_tick = s_q.sync2.ref_clock_in & ~s_q.prev.ref_clock_in;
    assign osc_tick = s_q.sync2.pll_clock_in & ~s_q.prev.pll_clock_in;

    // Frequency comparison of loop oscillator against reference.
    cdrmc_freq_monitor #(
        .WINDOW_REFS(WINDOW_REFS)
    ) u_mon (
        .aclk(aclk),
        .aresetn(aresetn),
        .ref_tick(ref_tick),
        .osc_tick(osc_tick),
        .rate_high(s_q.sync2.rate_select_high),
        .freq_ok(freq_ok),
        .measured(freq_count)
    );

    // ****************************************************************
    // Next-state logic.
    // ****************************************************************
    // Mode selection, output muxing, events and the register slave.
    always_comb begin
        cdrmc_pins_t p;
        logic bypass_eff;
        logic illegal;
        logic force_ref;
        logic clk_sel;
        logic data_sel;
        logic [IRQ_W-1:0] events;
        logic [IRQ_W-1:0] clear;
        logic [2:0] idx;
        p = s_q.sync2;
        bypass_eff = p.bypass & p.rate_select_high;
        illegal = p.bypass & ~p.rate_select_high;
        force_ref = ~p.signal_present_in | ~p.force_reference_lock_n | s_q.ctrl_force_ref;
        clear = '0;
        idx = IDX_NONE;
        clk_sel = 1'b0;
        data_sel = 1'b0;
        events = '0;
        s_d = s_q;
        // Two-stage synchronisers for every pin.
        s_d.sync1 = pins;
        s_d.sync2 = s_q.sync1;
        s_d.prev = s_q.sync2;
        // Bypass wins; the disallowed bypass setting is ignored and flagged.
        if (bypass_eff) begin
            s_d.mode = MODE_BYPASS;
        end else if (force_ref) begin
            s_d.mode = MODE_LOS; // see [R3]
        end else begin
            s_d.mode = MODE_NORMAL;
        end
        case (s_d.mode)
            MODE_NORMAL: begin
                clk_sel = p.pll_clock_in; // see [R10]
                data_sel = p.line_data_in;
            end
            MODE_LOS: begin
                clk_sel = p.pll_clock_in; // see [R5]
                data_sel = 1'b0; // see [R4]
            end
            default: begin
                clk_sel = ~p.ref_clock_in; // see [R11]
                data_sel = p.line_data_in;
            end
        endcase
        s_d.line = '{clock_out: clk_sel, clock_out_complement: ~clk_sel,
                     data_out: data_sel, data_out_complement: ~data_sel};
        s_d.track_ref = (s_d.mode == MODE_LOS); // see [R6]
        s_d.ratio = p.rate_select_high ? RATIO_HIGH : RATIO_LOW; // see [R1]
        // Lock only while tracking line data at the right frequency.
        s_d.lock = (s_d.mode == MODE_NORMAL) && freq_ok; // see [R7] see [R8] see [R9]
        events[IRQ_LOS] = (s_d.mode == MODE_LOS) && (s_q.mode != MODE_LOS);
        events[IRQ_LOCK_LOST] = s_q.lock & ~s_d.lock;
        events[IRQ_LOCK_GAIN] = ~s_q.lock & s_d.lock;
        events[IRQ_ILLEGAL] = illegal;
        // Write response handshake completes.
        if (s_q.bvalid && bready) begin
            s_d.bvalid = 1'b0;
        end
        // Capture address and data independently, in either order.
        if (awvalid && awready) begin
            s_d.aw_have = 1'b1;
            s_d.aw_addr = awaddr;
        end
        if (wvalid && wready) begin
            s_d.w_have = 1'b1;
            s_d.w_data = wdata;
            s_d.w_strb = wstrb;
        end
        // Perform the write once both halves are held.
        if (s_q.aw_have && s_q.w_have && !s_q.bvalid) begin
            idx = cdrmc_decode(s_q.aw_addr);
            s_d.aw_have = 1'b0;
            s_d.w_have = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp = RESP_OKAY;
            if (idx == IDX_CTRL) begin
                if (s_q.w_strb[0]) begin
                    s_d.ctrl_force_ref = s_q.w_data[CTRL_FORCE_REF];
                end
            end else if (idx == IDX_IRQ_STATUS) begin
                if (s_q.w_strb[0]) begin
                    clear = s_q.w_data[IRQ_W-1:0];
                end
            end else if (idx == IDX_IRQ_MASK) begin
                if (s_q.w_strb[0]) begin
                    s_d.irq_mask = s_q.w_data[IRQ_W-1:0];
                end
            end else if (idx == IDX_NONE) begin
                s_d.bresp = RESP_SLVERR;
            end
        end
        // Sticky events; a new event wins over a clear in the same cycle.
        s_d.irq_status = (s_q.irq_status & ~clear) | events;
        // Read response handshake completes.
        if (s_q.rvalid && rready) begin
            s_d.rvalid = 1'b0;
        end
        // Accept a read and register its data.
        if (arvalid && arready) begin
            s_d.rvalid = 1'b1;
            s_d.rresp = RESP_OKAY;
            s_d.rdata = '0;
            if (cdrmc_decode(araddr) == IDX_CTRL) begin
                s_d.rdata[CTRL_FORCE_REF] = s_q.ctrl_force_ref;
            end else if (cdrmc_decode(araddr) == IDX_STATUS) begin
                s_d.rdata = {18'h0, s_q.ratio, 2'h0, illegal, freq_ok,
                             p.rate_select_high, s_q.mode == MODE_BYPASS,
                             s_q.lock, s_q.mode == MODE_LOS};
            end else if (cdrmc_decode(araddr) == IDX_IRQ_STATUS) begin
                s_d.rdata[IRQ_W-1:0] = s_q.irq_status;
            end else if (cdrmc_decode(araddr) == IDX_IRQ_MASK) begin
                s_d.rdata[IRQ_W-1:0] = s_q.irq_mask;
            end else if (cdrmc_decode(araddr) == IDX_FREQ_COUNT) begin
                s_d.rdata[CNT_W-1:0] = freq_count;
            end else begin
                s_d.rresp = RESP_SLVERR;
            end
        end
    end

    // State register with synchronous reset.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q <= STATE_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // ****************************************************************
    // Outputs.
    // ****************************************************************
    assign line_out = s_q.line;
    assign lock_indicator_pin = s_q.lock;
    assign loop_track_ref = s_q.track_ref;
    assign loop_divide_ratio = s_q.ratio;
    assign irq = |(s_q.irq_status & s_q.irq_mask);
    assign awready = ~s_q.aw_have & ~s_q.bvalid;
    assign wready = ~s_q.w_have & ~s_q.bvalid;
    assign bvalid = s_q.bvalid;
    assign bresp = s_q.bresp;
    assign arready = ~s_q.rvalid;
    assign rvalid = s_q.rvalid;
    assign rdata = s_q.rdata;
    assign rresp = s_q.rresp;

    // ****************************************************************
    // Assertions and cover points.
    // ****************************************************************
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // Helper: the synchronised inputs demand the muted state.
    logic force_now;
    assign force_now = ~s_q.sync2.bypass & (~s_q.sync2.signal_present_in
                       | ~s_q.sync2.force_reference_lock_n);

    los_entry_a: assert property (force_now |=> s_q.mode == MODE_LOS) // see [R3]
        else $error("forcing inputs low did not enter the muted state");
    los_data_mute_a: assert property (force_now |=> !line_out.data_out // see [R4]
            && line_out.data_out_complement)
        else $error("data not muted in the muted state");
    los_clock_pll_a: assert property (force_now |=> line_out.clock_out // see [R5]
            == $past(s_q.sync2.pll_clock_in))
        else $error("muted state clock not taken from the loop");
    track_ref_a: assert property (force_now |=> loop_track_ref) // see [R6]
        else $error("loop not forced onto the reference");
    lock_freq_a: assert property (!freq_ok |=> !lock_indicator_pin) // see [R7]
        else $error("lock high with frequency out of tolerance");
    lock_forced_a: assert property (force_now |=> !lock_indicator_pin) // see [R8]
        else $error("lock high while forced onto the reference");
    lock_cause_a: assert property ($rose(lock_indicator_pin) |-> // see [R9]
            $past(freq_ok) && s_q.mode == MODE_NORMAL)
        else $error("lock rose without tracking line data");
    normal_data_a: assert property (s_q.mode == MODE_NORMAL |-> // see [R10]
            line_out.data_out == $past(s_q.sync2.line_data_in)
            && line_out.data_out_complement != line_out.data_out)
        else $error("normal mode data not retimed line data");
    bypass_clock_a: assert property (s_q.sync2.bypass && s_q.sync2.rate_select_high // see [R11]
            |=> line_out.clock_out == !$past(s_q.sync2.ref_clock_in))
        else $error("bypass clock is not the inverted reference");
    rate_ratio_a: assert property (s_q.sync2.rate_select_high |=> // see [R1]
            loop_divide_ratio == RATIO_HIGH)
        else $error("high rate did not select the high ratio");
    bresp_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped before taken");

    los_seen_c: cover property (s_q.mode == MODE_NORMAL ##1 s_q.mode == MODE_LOS);
    lock_gain_c: cover property ($rose(lock_indicator_pin));
    bypass_seen_c: cover property (s_q.mode == MODE_BYPASS);
    irq_seen_c: cover property ($rose(irq));

endmodule

// [verification/cdrmc_far_model.sv]
`timescale 1ns/10ps
// Receiver, loop oscillator and reference source beside the block.
module cdrmc_far_model (
    // Clock and rate.
    input wire logic aclk,
    input wire logic rate_high,
    // Slow level models of the far-side signals.
    output logic pll_clk,
    output logic ref_clk,
    output logic line_data
);
    int pc;
    int rc;
    int lc;
    initial begin
        pll_clk = 1'h0;
        ref_clk = 1'h0;
        line_data = 1'h0;
        pc = 0;
        rc = 0;
        lc = 0;
    end
    // Loop level flips every 3 cycles; the reference is ratio times slower.
    always @(posedge aclk) begin
        pc = (pc >= 2) ? 0 : pc + 1;
        if (pc == 0) pll_clk <= ~pll_clk;
        rc = (rc >= (rate_high ? 95 : 23)) ? 0 : rc + 1;
        if (rc == 0) ref_clk <= ~ref_clk;
        lc = lc + 1;
        line_data <= lc[2] ^ lc[4];
    end
endmodule

// [verification/sonet_cdr_mode_control_tb_top.sv]
`timescale 1ns/10ps
module sonet_cdr_mode_control_tb_top
    import cdrmc_pkg::*;
;
    logic aclk, aresetn, byp, frc_n, sig, rate, pllc, refc, line;
    cdrmc_pins_t pins;
    cdrmc_line_out_t lo;
    logic lock, trk, irq, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [5:0] ratio;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic [2:0] dh, rh;
    int fails, checks_done;
    assign pins = {byp, frc_n, sig, rate, pllc, refc, line};
    cdrmc_top #(.WINDOW_REFS(4)) i_dut (.aclk, .aresetn, .pins, .line_out(lo),
        .lock_indicator_pin(lock), .loop_track_ref(trk), .loop_divide_ratio(ratio), .irq,
        .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready,
        .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp);
    cdrmc_far_model i_far (.aclk, .rate_high(rate), .pll_clk(pllc), .ref_clk(refc),
        .line_data(line));
    initial begin
        aclk = 1'h0;
        forever #50 aclk = ~aclk;
    end
    // Pin history, three edges deep, to match the output latency.
    always @(posedge aclk) begin
        dh <= {dh[1:0], line};
        rh <= {rh[1:0], refc};
    end
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            fails++;
            $display("MISMATCH %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic summarize;
        if (fails == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // Register write: both halves offered together, each dropped once taken.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        forever begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'h0;
            if (wvalid && wready) wvalid <= 1'h0;
            if (bvalid) break;
        end
        chk("bresp", (a > 8'h10) ? RESP_SLVERR : RESP_OKAY, bresp);
        bready <= 1'h0;
        @(posedge aclk);
    endtask
    task automatic rdr(input logic [7:0] a);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        forever begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'h0;
            if (rvalid) break;
        end
        rd = rdata;
        chk("rresp", (a > 8'h10) ? RESP_SLVERR : RESP_OKAY, rresp);
        rready <= 1'h0;
        @(posedge aclk);
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge aclk);
        @(negedge aclk);
    endtask
    task automatic t_normal;
        repeat (3000) begin
            @(negedge aclk);
            if (lock === 1'h1) break;
        end
        settle(1);
        chk("lock", 1'h1, lock);
        chk("ratio", RATIO_HIGH, ratio);
        repeat (8) begin
            @(negedge aclk);
            chk("data", {dh[2], ~dh[2]}, {lo.data_out, lo.data_out_complement});
        end
        @(posedge aclk);
    endtask
    task automatic t_sig_lost;
        wr(ADDR_IRQ_MASK, 32'h1);
        sig <= 1'h0;
        settle(3);
        chk("muted", 2'h1, {lo.data_out, lo.data_out_complement});
        chk("track", 1'h1, trk);
        chk("lock", 1'h0, lock);
        chk("irq", 1'h1, irq);
        @(posedge aclk);
        rdr(ADDR_IRQ_STATUS);
        chk("irq_status", 1'h1, rd[0]);
        sig <= 1'h1;
        wr(ADDR_IRQ_STATUS, 32'h1);
        chk("irq_clear", 1'h0, irq);
    endtask
    task automatic t_force;
        frc_n <= 1'h0;
        settle(3);
        chk("forced", 2'h1, {lo.data_out, lo.data_out_complement});
        chk("lock_f", 1'h0, lock);
        @(posedge aclk);
        frc_n <= 1'h1;
    endtask
    task automatic t_bypass;
        byp <= 1'h1; // Only while rate select is high.
        settle(3);
        repeat (40) begin
            repeat (5) @(negedge aclk);
            chk("byp_clk", {~rh[2], rh[2]}, {lo.clock_out, lo.clock_out_complement});
        end
        @(posedge aclk);
        byp <= 1'h0;
    endtask
    task automatic t_low_rate;
        rate <= 1'h0;
        settle(3);
        chk("ratio_low", RATIO_LOW, ratio);
        @(posedge aclk);
        rate <= 1'h1;
        rdr(8'h40);
        chk("unmapped", 32'h0, rd);
    endtask
    initial begin
        repeat (20000) @(posedge aclk);
        fails++;
        summarize();
    end
    initial begin
        {byp, awvalid, wvalid, bready, arvalid, rready, aresetn} = 7'h0;
        {frc_n, sig, rate} = 3'h7;
        {awaddr, araddr, wdata, wstrb} = 52'h0000f;
        settle(6);
        chk("reset_out", 4'h5, lo);
        chk("reset_lock", 1'h0, lock);
        @(posedge aclk);
        aresetn <= 1'h1;
        t_normal();
        t_sig_lost();
        t_force();
        t_bypass();
        t_low_rate();
        summarize();
    end
endmodule
